// file: tb/ohm_meter_tb.sv
// Self-checking bench for the operating-hours and energy meter.
// Assumes ohm_meter built with HOUR_CYCLES = 1: one hour per enabled edge.
`timescale 1ns/1ps
module ohm_meter_tb;
    import ohm_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, irq_o;
    logic [3:0] alm;
    // ce, run, sel, brake, heat, standby, supply, fan, mot, gen
    logic [9:0] ev_r = 10'h200;
    logic [31:0] rdat;
    logic rerr;
    int fails = 0;
    int total_checks = 0;

    always #2.5 mclk_i = ~mclk_i;

    ohm_meter #(.HOUR_CYCLES(40'h1)) i_dut (
        .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ev_r[9]),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .run_i(ev_r[8]), .motor_sel_i(ev_r[7]), .dc_brake_i(ev_r[6]),
        .heating_i(ev_r[5]), .standby_i(ev_r[4]), .supply_on_i(ev_r[3]),
        .fan_on_i(ev_r[2]), .mot_energy_i(ev_r[1]), .gen_energy_i(ev_r[0]),
        .motor1_service_alarm_o(alm[0]), .motor2_service_alarm_o(alm[1]),
        .poweron_service_alarm_o(alm[2]), .fan_service_alarm_o(alm[3]),
        .irq_o(irq_o)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Idle edge first, so a release and a new setup never share a step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        @(posedge mclk_i);
        while (pready_o !== 1'b1) begin
            n++;
            if (n > 16) begin
                fails++;
                wrap_up();
            end
            @(posedge mclk_i);
        end
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
        apb(1'b0, a, 32'h0);
        check(rdat, exp, what);
    endtask

    // Holds an event pattern for exactly n sampled edges
    task automatic ev(input logic [9:0] v, input int n);
        @(posedge mclk_i);
        ev_r <= v;
        repeat (n) @(posedge mclk_i);
        ev_r <= 10'h200;
    endtask

    function automatic logic [7:0] ma(input int i, input logic [7:0] sub);
        return OFS_METER_BASE + METER_STRIDE * 8'(i) + sub;
    endfunction

    function automatic logic [7:0] ea(input int i, input logic [7:0] sub);
        return OFS_MWH_BASE + ENERGY_STRIDE * 8'(i) + sub;
    endfunction

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk_i);
        srst_i <= 1'b0;
        for (int i = 0; i < N_METERS; i++) begin
            rchk(ma(i, SUB_INTERVAL), 32'h0, "interval reset");
        end
        apb(1'b1, OFS_IRQ_MASK, 32'h3f);
        apb(1'b1, ma(M_MOTOR1, SUB_INTERVAL), 32'h2);
        ev(10'h340, 3);
        ev(10'h320, 3);
        ev(10'h310, 3);
        ev(10'h100, 3);
        rchk(ma(M_MOTOR1, SUB_HOURS), 32'h0, "m1 blocked");
        ev(10'h300, 2);
        ev(10'h380, 3);
        rchk(ma(M_MOTOR1, SUB_HOURS), 32'h2, "m1 hours");
        rchk(ma(M_MOTOR1, SUB_ELAPSED), 32'h2, "m1 elapsed");
        rchk(ma(M_MOTOR2, SUB_HOURS), 32'h3, "m2 hours");
        check(32'(alm), 32'h1, "alarms");
        check(32'(irq_o), 32'h1, "irq");
        rchk(OFS_IRQ_STATUS, 32'h1, "status");
        rchk(OFS_IRQ_STATUS, 32'h0, "status again");
        @(negedge mclk_i);
        check(32'(irq_o), 32'h0, "irq");
        $display("test motors done");

        apb(1'b1, OFS_INTERVAL_CLEAR_SELECT, 32'h1);
        rchk(OFS_INTERVAL_CLEAR_SELECT, 32'h0, "selector");
        rchk(ma(M_MOTOR1, SUB_ELAPSED), 32'h0, "m1 elapsed");
        rchk(ma(M_MOTOR1, SUB_HOURS), 32'h2, "m1 hours");
        check(32'(alm), 32'h0, "alarms");
        apb(1'b1, OFS_INTERVAL_CLEAR_SELECT, 32'h2);
        rchk(ma(M_MOTOR2, SUB_ELAPSED), 32'h0, "m2 elapsed");
        $display("test clear done");

        apb(1'b1, ma(M_POWERON, SUB_INTERVAL), 32'h3);
        apb(1'b1, ma(M_FAN, SUB_INTERVAL), 32'h1);
        ev(10'h20c, 3);
        @(negedge mclk_i);
        check(32'(alm), 32'hc, "alarms");
        rchk(ma(M_FAN, SUB_HOURS), 32'h3, "fan hours");
        rchk(ma(M_POWERON, SUB_HOURS), 32'h3, "pon hours");
        apb(1'b1, OFS_INTERVAL_CLEAR_SELECT, 32'h4);
        rchk(ma(M_FAN, SUB_ELAPSED), 32'h0, "fan elapsed");
        check(32'(alm), 32'h4, "alarms");
        // Stray upper bits make the code illegal: power-on must survive
        apb(1'b1, OFS_INTERVAL_CLEAR_SELECT, 32'hb);
        rchk(ma(M_POWERON, SUB_ELAPSED), 32'h3, "pon elapsed");
        apb(1'b1, OFS_INTERVAL_CLEAR_SELECT, 32'h3);
        rchk(OFS_IRQ_STATUS, 32'hc, "status");
        check(32'(alm), 32'h0, "alarms");
        $display("test power and fan done");

        apb(1'b1, ma(M_MOTOR1, SUB_INTERVAL), 32'hea61);
        rchk(ma(M_MOTOR1, SUB_INTERVAL), 32'hea60, "interval max");
        apb(1'b0, 8'h50, 32'h0);
        check(rdat, 32'h0, "unmapped data");
        check(32'(rerr), 32'h1, "unmapped error");
        $display("test limits done");

        ev(10'h202, 10001);
        ev(10'h201, 5);
        rchk(ea(E_MOT, SUB_KWH), 32'h1, "kwh mot");
        rchk(ea(E_MOT, 8'h00), 32'h1, "mwh mot");
        rchk(ea(E_GEN, SUB_KWH), 32'h5, "kwh gen");
        rchk(ea(E_GEN, 8'h00), 32'h0, "mwh gen");
        rchk(OFS_IRQ_STATUS, 32'h10, "status");
        $display("test energy done");

        // Power-on meter already holds 3 h
        ev(10'h208, 59997);
        rchk(ma(M_POWERON, SUB_HOURS), 32'hea60, "pon top");
        ev(10'h208, 1);
        rchk(ma(M_POWERON, SUB_HOURS), 32'h0, "pon wrap");
        ev(10'h208, 1);
        rchk(ma(M_POWERON, SUB_HOURS), 32'h1, "pon after");
        $display("test wrap done");
        wrap_up();
    end
endmodule // ohm_meter_tb

// file: verilog/ohm_meter.sv
// Operating-hours meters, service intervals and energy meters.
// Assumes event inputs already qualified and synchronous to mclk_i.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ohm_meter #(
    parameter logic [ohm_pkg::PRE_W-1:0] HOUR_CYCLES =
        ohm_pkg::PRE_W'(ohm_pkg::HOUR_CYC)
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Qualified drive events
    input wire logic run_i,
    input wire logic motor_sel_i,
    input wire logic dc_brake_i,
    input wire logic heating_i,
    input wire logic standby_i,
    input wire logic supply_on_i,
    input wire logic fan_on_i,
    input wire logic mot_energy_i,
    input wire logic gen_energy_i,
    // Alarms and interrupt
    output logic motor1_service_alarm_o,
    output logic motor2_service_alarm_o,
    output logic poweron_service_alarm_o,
    output logic fan_service_alarm_o,
    output logic irq_o
);
    import ohm_pkg::*;

    ohm_state_t st_r;
    ohm_state_t st_nxt;
    logic [N_METERS-1:0] count_en;
    logic [N_METERS-1:0] tick;
    logic [N_ENERGY-1:0] e_inc;
    logic setup_ph;
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic hit;
    logic [31:0] rd_val;
    logic [IRQ_W-1:0] irq_set;
    logic [15:0] elap_inc;
    logic [15:0] wval;

    // -------------------------------------------------------------
    // Meter qualification
    // -------------------------------------------------------------
    logic motor_runs;
    // Braking, heating and standby are not operating time
    assign motor_runs = run_i & ~dc_brake_i & ~heating_i & ~standby_i;
    assign count_en[M_MOTOR1] = motor_runs & ~motor_sel_i;
    assign count_en[M_MOTOR2] = motor_runs & motor_sel_i;
    assign count_en[M_POWERON] = supply_on_i;
    assign count_en[M_FAN] = fan_on_i;
    assign e_inc[E_MOT] = mot_energy_i;
    assign e_inc[E_GEN] = gen_energy_i;

    // -------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------
    // Zero-wait access phase; read data captured in the setup phase
    assign setup_ph = psel_i & ~penable_i;
    assign access = psel_i & penable_i & ce_i;
    assign wr_acc = access & pwrite_i;
    assign rd_acc = access & ~pwrite_i;
    assign pready_o = access;
    assign prdata_o = st_r.prdata;
    assign pslverr_o = access & ~hit;

    always_comb begin
        hit = 1'b0;
        rd_val = 32'h0000_0000;
        if (paddr_i == OFS_INTERVAL_CLEAR_SELECT) begin
            hit = 1'b1;
            rd_val = {29'h0000_0000, st_r.clr_sel};
        end
        for (int i = 0; i < N_METERS; i++) begin
            if (paddr_i == 8'(OFS_METER_BASE + METER_STRIDE * i +
                              SUB_HOURS)) begin
                hit = 1'b1;
                rd_val = {16'h0000, st_r.hours[i]};
            end
            if (paddr_i == 8'(OFS_METER_BASE + METER_STRIDE * i +
                              SUB_INTERVAL)) begin
                hit = 1'b1;
                rd_val = {16'h0000, st_r.ival[i]};
            end
            if (paddr_i == 8'(OFS_METER_BASE + METER_STRIDE * i +
                              SUB_ELAPSED)) begin
                hit = 1'b1;
                rd_val = {16'h0000, st_r.elap[i]};
            end
        end
        for (int e = 0; e < N_ENERGY; e++) begin
            if (paddr_i == 8'(OFS_MWH_BASE + ENERGY_STRIDE * e)) begin
                hit = 1'b1;
                rd_val = {16'h0000, st_r.mwh[e]};
            end
            if (paddr_i == 8'(OFS_MWH_BASE + ENERGY_STRIDE * e +
                              SUB_KWH)) begin
                hit = 1'b1;
                rd_val = {18'h00000, st_r.kwh[e]};
            end
        end
        if (paddr_i == OFS_IRQ_STATUS) begin
            hit = 1'b1;
            rd_val = {26'h0000000, st_r.irq_stat};
        end
        if (paddr_i == OFS_IRQ_MASK) begin
            hit = 1'b1;
            rd_val = {26'h0000000, st_r.irq_mask};
        end
        if (paddr_i == OFS_ALARMS) begin
            hit = 1'b1;
            rd_val = {28'h0000000, st_r.alarm};
        end
    end

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        irq_set = '0;
        tick = '0;
        elap_inc = 16'h0000;
        // Oversized writes saturate rather than wrap
        wval = (pwdata_i[31:16] != 16'h0000 || pwdata_i[15:0] > HOURS_MAX)
            ? HOURS_MAX : pwdata_i[15:0];

        // Selector acts one cycle, then falls back to no action
        st_nxt.clr_sel = CLR_NONE;

        for (int i = 0; i < N_METERS; i++) begin
            // Prescaler only moves while the meter counts
            if (count_en[i]) begin
                if (st_r.pre[i] == HOUR_CYCLES - 1'b1) begin
                    st_nxt.pre[i] = '0;
                    tick[i] = 1'b1;
                end else begin
                    st_nxt.pre[i] = st_r.pre[i] + 1'b1;
                end
            end
            if (tick[i]) begin
                st_nxt.hours[i] = (st_r.hours[i] >= HOURS_MAX)
                    ? 16'h0000 : st_r.hours[i] + 1'b1;
                // Elapsed hours stop at the limit instead of wrapping
                elap_inc = (st_r.elap[i] >= HOURS_MAX)
                    ? HOURS_MAX : st_r.elap[i] + 1'b1;
                st_nxt.elap[i] = elap_inc;
                if (st_r.ival[i] != 16'h0000 &&
                    elap_inc >= st_r.ival[i]) begin
                    if (!st_r.alarm[i]) begin
                        irq_set[i] = 1'b1;
                    end
                end
            end
            // Clear restarts the interval; a same-cycle raise still wins
            if (st_r.clr_sel == 3'(i + 1)) begin
                st_nxt.alarm[i] = 1'b0;
                st_nxt.elap[i] = 16'h0000;
            end
            if (irq_set[i]) begin
                st_nxt.alarm[i] = 1'b1;
            end
        end

        for (int e = 0; e < N_ENERGY; e++) begin
            if (e_inc[e]) begin
                if (st_r.kwh[e] >= KWH_TENTHS_MAX) begin
                    st_nxt.kwh[e] = 14'h0000;
                    st_nxt.mwh[e] = st_r.mwh[e] + 1'b1;
                    irq_set[IRQ_CARRY + e] = 1'b1;
                end else begin
                    st_nxt.kwh[e] = st_r.kwh[e] + 1'b1;
                end
            end
        end

        if (setup_ph) begin
            st_nxt.prdata = rd_val;
        end
        if (wr_acc) begin
            if (paddr_i == OFS_INTERVAL_CLEAR_SELECT &&
                pwdata_i[31:3] == 29'h0000_0000 &&
                pwdata_i[2:0] <= CLR_LAST) begin
                st_nxt.clr_sel = pwdata_i[2:0];
            end
            for (int i = 0; i < N_METERS; i++) begin
                if (paddr_i == 8'(OFS_METER_BASE + METER_STRIDE * i +
                                  SUB_INTERVAL)) begin
                    st_nxt.ival[i] = wval;
                end
            end
            if (paddr_i == OFS_IRQ_MASK) begin
                st_nxt.irq_mask = pwdata_i[IRQ_W-1:0];
            end
        end
        // Read clears only what was reported, so no event is lost
        if (rd_acc && paddr_i == OFS_IRQ_STATUS) begin
            st_nxt.irq_stat = st_r.irq_stat & ~st_r.prdata[IRQ_W-1:0];
        end
        st_nxt.irq_stat = st_nxt.irq_stat | irq_set;
    end

    // -------------------------------------------------------------
    // State register
    // -------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign motor1_service_alarm_o = st_r.alarm[M_MOTOR1];
    assign motor2_service_alarm_o = st_r.alarm[M_MOTOR2];
    assign poweron_service_alarm_o = st_r.alarm[M_POWERON];
    assign fan_service_alarm_o = st_r.alarm[M_FAN];
    assign irq_o = |(st_r.irq_stat & st_r.irq_mask);

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);

    a_run_gating: assert property (
        (dc_brake_i || heating_i || standby_i) && ce_i
        |=> $stable(st_r.pre[M_MOTOR1]) && $stable(st_r.pre[M_MOTOR2]))
        else $error("motor meter moved while not operating");
    a_motor_select: assert property (
        ce_i && !motor_sel_i |=> $stable(st_r.hours[M_MOTOR2]))
        else $error("unselected motor meter advanced");
    a_interval_max: assert property (
        st_r.ival[M_MOTOR1] <= HOURS_MAX && st_r.ival[M_FAN] <= HOURS_MAX)
        else $error("interval setting above limit");
    a_alarm_raise: assert property (
        ce_i && tick[M_MOTOR1] && st_r.ival[M_MOTOR1] != 16'h0000
        && st_r.elap[M_MOTOR1] + 16'h0001 == st_r.ival[M_MOTOR1]
        |=> motor1_service_alarm_o)
        else $error("motor alarm not raised at interval");
    a_poweron_count: assert property (
        ce_i && supply_on_i
        |=> st_r.hours[M_POWERON] != $past(st_r.hours[M_POWERON])
        || st_r.pre[M_POWERON] == $past(st_r.pre[M_POWERON]) + 1'b1)
        else $error("power-on meter did not advance");
    a_clear_restart: assert property (
        ce_i && st_r.clr_sel == 3'h4 |=> st_r.elap[M_FAN] == 16'h0000
        && (!fan_service_alarm_o || $past(irq_set[M_FAN])))
        else $error("fan clear did not restart interval");
    a_select_return: assert property (
        ce_i && st_r.clr_sel != CLR_NONE && !wr_acc
        |=> st_r.clr_sel == CLR_NONE)
        else $error("clear selector did not return to no action");
    a_zero_disable: assert property (
        ce_i && st_r.ival[M_POWERON] == 16'h0000 && !poweron_service_alarm_o
        |=> !poweron_service_alarm_o)
        else $error("alarm raised with zero interval");
    a_hours_wrap: assert property (
        ce_i && tick[M_POWERON] && st_r.hours[M_POWERON] == HOURS_MAX
        |=> st_r.hours[M_POWERON] == 16'h0000)
        else $error("hours meter did not wrap");
    a_kwh_roll: assert property (
        ce_i && mot_energy_i && st_r.kwh[E_MOT] == KWH_TENTHS_MAX
        |=> st_r.kwh[E_MOT] == 14'h0000
        && st_r.mwh[E_MOT] == $past(st_r.mwh[E_MOT]) + 16'h0001)
        else $error("kWh did not roll into MWh");
    a_energy_split: assert property (
        ce_i && !gen_energy_i |=> $stable(st_r.kwh[E_GEN]))
        else $error("generating meter moved without event");
    a_ce_freeze: assert property (
        !ce_i |=> $stable(st_r))
        else $error("state moved while clock enable low");

    // Idle meters hold prescaler and hours, so a pause loses no time
    a_supply_gating: assert property (
        ce_i && !supply_on_i
        |=> $stable(st_r.pre[M_POWERON]) && $stable(st_r.hours[M_POWERON]))
        else $error("power-on meter moved without supply");
    a_fan_gating: assert property (
        ce_i && !fan_on_i
        |=> $stable(st_r.pre[M_FAN]) && $stable(st_r.hours[M_FAN]))
        else $error("fan meter moved while fan stopped");
    a_motor1_select: assert property (
        ce_i && motor_sel_i |=> $stable(st_r.hours[M_MOTOR1]))
        else $error("unselected motor meter advanced");
    a_poweron_alarm: assert property (
        ce_i && tick[M_POWERON] && st_r.ival[M_POWERON] != 16'h0000
        && st_r.elap[M_POWERON] + 16'h0001 == st_r.ival[M_POWERON]
        |=> poweron_service_alarm_o)
        else $error("power-on alarm not raised at interval");
    a_fan_alarm: assert property (
        ce_i && tick[M_FAN] && st_r.ival[M_FAN] != 16'h0000
        && st_r.elap[M_FAN] + 16'h0001 == st_r.ival[M_FAN]
        |=> fan_service_alarm_o)
        else $error("fan alarm not raised at interval");
    // An illegal code must not reach the selector, not even for a cycle
    a_selector_ignore: assert property (
        wr_acc && paddr_i == OFS_INTERVAL_CLEAR_SELECT
        && (pwdata_i[31:3] != 29'h0000_0000 || pwdata_i[2:0] > CLR_LAST)
        |=> st_r.clr_sel == CLR_NONE)
        else $error("illegal clear code accepted");
    // Read clear drops exactly the bits captured for the reader
    a_status_clear: assert property (
        rd_acc && paddr_i == OFS_IRQ_STATUS && irq_set == '0
        |=> (st_r.irq_stat & $past(st_r.prdata[IRQ_W-1:0])) == '0)
        else $error("status bits survived the read");

    c_motor_alarm: cover property (motor1_service_alarm_o);
    c_clear_alarm: cover property (
        fan_service_alarm_o ##1 st_r.clr_sel == 3'h4 ##1 !fan_service_alarm_o);
    c_mwh_carry: cover property (st_r.mwh[E_GEN] != 16'h0000);
    c_irq: cover property (irq_o);
    c_hours_wrap: cover property (
        tick[M_POWERON] && st_r.hours[M_POWERON] == HOURS_MAX);

endmodule // ohm_meter

// file: verilog/ohm_pkg.sv
// Package for the operating-hours and energy meter block.
// Assumes one 200 MHz clock and an APB slave with 8-bit byte addresses.
package ohm_pkg;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam longint unsigned HOUR_NS = 64'd3600000000000;
    localparam longint unsigned CLK_NS = 64'd5;
    // One hour of clock cycles (720e9), shortened in simulation
    localparam longint unsigned HOUR_CYC = HOUR_NS / CLK_NS;
    localparam int PRE_W = 40;

    // -------------------------------------------------------------
    // Counting limits
    // -------------------------------------------------------------
    localparam logic [15:0] HOURS_MAX = 16'hea60;   // 60000 h
    localparam logic [13:0] KWH_TENTHS_MAX = 14'h270f; // 999.9 kWh
    localparam int N_METERS = 4;
    localparam int N_ENERGY = 2;

    // Meter indexes; selector code is index + 1
    localparam int M_MOTOR1 = 0;
    localparam int M_MOTOR2 = 1;
    localparam int M_POWERON = 2;
    localparam int M_FAN = 3;
    localparam int E_MOT = 0;
    localparam int E_GEN = 1;

    // interval_clear_select codes
    localparam logic [2:0] CLR_NONE = 3'h0;
    localparam logic [2:0] CLR_LAST = 3'h4;

    // -------------------------------------------------------------
    // Register map (byte offsets)
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_INTERVAL_CLEAR_SELECT = 8'h00;
    localparam logic [7:0] OFS_METER_BASE = 8'h04;
    localparam logic [7:0] METER_STRIDE = 8'h0c;
    localparam logic [7:0] SUB_HOURS = 8'h00;
    localparam logic [7:0] SUB_INTERVAL = 8'h04;
    localparam logic [7:0] SUB_ELAPSED = 8'h08;
    localparam logic [7:0] OFS_MWH_BASE = 8'h34;
    localparam logic [7:0] ENERGY_STRIDE = 8'h08;
    localparam logic [7:0] SUB_KWH = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h44;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
    localparam logic [7:0] OFS_ALARMS = 8'h4c;

    // Interrupt status bits: 0..3 alarm raised, 4..5 MWh carry
    localparam int IRQ_W = 6;
    localparam int IRQ_CARRY = 4;

    // -------------------------------------------------------------
    // Whole block state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [N_METERS-1:0][PRE_W-1:0] pre;
        logic [N_METERS-1:0][15:0] hours;
        logic [N_METERS-1:0][15:0] ival;
        logic [N_METERS-1:0][15:0] elap;
        logic [N_METERS-1:0] alarm;
        logic [2:0] clr_sel;
        logic [N_ENERGY-1:0][13:0] kwh;
        logic [N_ENERGY-1:0][15:0] mwh;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] prdata;
    } ohm_state_t;

endpackage
